// File: design/swcm_top.sv
/*
 Service window timer and clock monitor with an APB register slave.
 Assumes instr_tick pulses once per instruction cycle, halt_mode and
 idle_mode come from the core, and shared_fault_pin is the Schmitt
 level of the open-drain fault wire, pulled up outside.
*/
`timescale 1ns/1ps

// Contract
// (RULE_01) Service before 2048 cycles is early
// (RULE_02) Top bits pick 8k to 64k upper bound
// (RULE_03) Key 01100 in bits 5..1 checked
// (RULE_04) Bit 0 enables clock monitor
// (RULE_05) Both detectors silent during reset
// (RULE_06) Reset arms max window, monitor on
// (RULE_07) First keyed write latches config once
// (RULE_08) Later writes compared; mismatch is error
// (RULE_09) Software services before upper bound
// (RULE_10) Services spaced one lower bound apart
// (RULE_11) First valid write restarts window
// (RULE_12) Fault held 16..32 cycles after low
// (RULE_13) Window restarts when pin returns high
// (RULE_14) Writes ignored while fault driven
// (RULE_15) Monitor drives low, releases after recovery
// (RULE_16) Pass 10 kHz, reject below 10 Hz
// (RULE_17) Key field reads as zeros
// (RULE_18) Halt and idle stop timer, not monitor
// (RULE_19) Halt exit resumes or reloads window
// (RULE_20) Idle exit is an automatic service
// (RULE_21) Idle counter unreset; pending every 4096
// (RULE_22) First service never early
// (RULE_23) Both errors ORed onto fault pin
module swcm_top import swcm_pkg::*; #(
    parameter int CM_LIMIT = CM_LIMIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_tick,
    input wire logic halt_mode,
    input wire logic idle_mode,
    input wire logic shared_fault_pin,
    output logic fault_out_n,
    output logic fault_out_n_oe
);
    // ==========================================================
    // Parameter check
    if (CM_LIMIT < 2 || CM_LIMIT >= 1048576) begin : g_bad_limit
        $error("CM_LIMIT out of range");
    end

    function automatic logic [16:0] upper_bound(input logic [1:0] sel);
        upper_bound = UPPER_BASE_TICKS << sel;
    endfunction

    localparam logic [19:0] CM_LIM = 20'(CM_LIMIT);

    // ==========================================================
    // State
    swcm_wd_state_type state_reg, state_next;
    logic [16:0] win_cnt_reg, win_cnt_next;
    logic [4:0] wd_rel_reg, wd_rel_next;
    logic [4:0] cm_rel_reg, cm_rel_next;
    logic [19:0] gap_reg, gap_next;
    logic cm_drive_reg, cm_drive_next;
    logic [1:0] sel_reg, sel_next;
    logic cm_en_reg, cm_en_next;
    logic first_done_reg, first_done_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic pend_reg, pend_next;
    logic [15:0] idle_cnt_reg;
    logic halt_q_reg;
    logic idle_q_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic oe_reg;

    // ==========================================================
    // APB decode
    wire access = psel & penable & pready_reg;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire hit_svc = paddr == ADDR_SERVICE;
    wire hit_st = paddr == ADDR_STATUS;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_idle = paddr == ADDR_IDLE_CNT;
    wire unmapped = ~(hit_svc | hit_st | hit_ctrl | hit_idle);

    // ==========================================================
    // Service checking
    wire [7:0] w = pwdata[7:0];
    wire in_run = state_reg == WD_RUN;
    wire wd_drive = state_reg == WD_DRIVE || state_reg == WD_HOLD;
    wire inhibit = halt_mode | idle_mode; // [RULE_18]
    wire halt_exit = halt_q_reg & ~halt_mode;
    wire idle_exit = idle_q_reg & ~idle_mode;
    // Any active drive blocks the write, including a monitor fault
    wire svc_wr = wr & hit_svc & in_run & ~oe_reg & ~inhibit; // [RULE_14]
    wire key_ok = w[KEY_MSB:KEY_LSB] == SVC_KEY; // [RULE_03]
    wire sel_ok = w[SEL_MSB:SEL_LSB] == sel_reg;
    wire cm_ok = w[CM_BIT] == cm_en_reg;
    wire early = win_cnt_reg < LOWER_TICKS; // [RULE_01] [RULE_10]
    wire later_ok = key_ok & sel_ok & cm_ok & ~early; // [RULE_08]
    wire svc_good = svc_wr & (first_done_reg ? later_ok : key_ok); // [RULE_22]
    wire svc_bad = svc_wr & ~svc_good;
    wire [16:0] upper = upper_bound(sel_reg); // [RULE_02]
    wire timeout = in_run & ~inhibit & (win_cnt_reg >= upper); // [RULE_09]
    wire wd_err = svc_bad | timeout;
    // Crystal, or delayed R/C start, reloads the window after halt
    wire halt_reload = halt_exit & ~(ctrl_reg[CTRL_RC_BIT] & ~ctrl_reg[CTRL_CLOCK_DELAY_SELECT_BIT]); // [RULE_19]

    // ==========================================================
    // Window counter and supervisor sequence
    always_comb begin
        win_cnt_next = win_cnt_reg;
        if (!in_run) begin
            win_cnt_next = 17'h00000; // [RULE_13]
        end else if (svc_good || idle_exit || halt_reload) begin
            win_cnt_next = 17'h00000; // [RULE_11] [RULE_20]
        end else if (instr_tick && !inhibit && win_cnt_reg < upper) begin
            win_cnt_next = win_cnt_reg + 17'h00001;
        end
    end

    always_comb begin
        state_next = state_reg;
        wd_rel_next = wd_rel_reg;
        case (state_reg)
            WD_RUN: begin
                wd_rel_next = 5'h00;
                if (wd_err) begin
                    state_next = WD_DRIVE;
                end
            end
            WD_DRIVE: begin
                if (!shared_fault_pin) begin
                    state_next = WD_HOLD;
                end
            end
            WD_HOLD: begin
                if (instr_tick) begin
                    wd_rel_next = wd_rel_reg + 5'h01;
                    if (wd_rel_reg == REL_TICKS - 5'h01) begin
                        state_next = WD_RELEASED; // [RULE_12]
                    end
                end
            end
            WD_RELEASED: begin
                if (shared_fault_pin) begin
                    state_next = WD_RUN; // [RULE_13]
                end
            end
            default: begin
                state_next = WD_RUN;
            end
        endcase
    end

    // ==========================================================
    // Configuration latch
    always_comb begin
        sel_next = sel_reg;
        cm_en_next = cm_en_reg;
        first_done_next = first_done_reg;
        if (svc_good && !first_done_reg) begin
            sel_next = w[SEL_MSB:SEL_LSB]; // [RULE_07]
            cm_en_next = w[CM_BIT]; // [RULE_04]
            first_done_next = 1'b1;
        end
    end

    // ==========================================================
    // Clock monitor: gap between ticks measured in bus clocks
    wire cm_slow = gap_reg >= CM_LIM; // [RULE_16]
    always_comb begin
        gap_next = gap_reg;
        cm_drive_next = cm_drive_reg;
        cm_rel_next = cm_rel_reg;
        if (instr_tick) begin
            gap_next = 20'h00000;
        end else if (!cm_slow) begin
            gap_next = gap_reg + 20'h00001;
        end
        if (!cm_en_reg) begin
            cm_drive_next = 1'b0;
            cm_rel_next = 5'h00;
        end else if (cm_slow) begin
            cm_drive_next = 1'b1; // [RULE_15]
            cm_rel_next = 5'h00;
        end else if (cm_drive_reg && instr_tick) begin
            cm_rel_next = cm_rel_reg + 5'h01;
            if (cm_rel_reg == REL_TICKS - 5'h01) begin
                cm_drive_next = 1'b0; // [RULE_15]
            end
        end
    end

    // ==========================================================
    // Software registers
    wire idle_wrap = instr_tick & (idle_cnt_reg[11:0] == IDLE_WRAP);
    always_comb begin
        ctrl_next = ctrl_reg;
        pend_next = pend_reg;
        if (wr && hit_ctrl) begin
            ctrl_next = pwdata[1:0];
        end
        if (wr && hit_st && pwdata[ST_PEND_BIT]) begin
            pend_next = 1'b0;
        end
        if (idle_wrap) begin
            pend_next = 1'b1; // [RULE_21]
        end
    end

    // Key field is never returned to software
    wire [31:0] rd_svc = {24'h000000, sel_reg, 5'h00, cm_en_reg}; // [RULE_17]
    wire [31:0] rd_st = {28'h0000000, first_done_reg, cm_drive_reg, wd_drive, pend_reg};
    always_comb begin
        prdata_next = 32'h00000000;
        if (psel && penable && !pwrite && !pready_reg) begin
            if (hit_svc) begin
                prdata_next = rd_svc;
            end else if (hit_st) begin
                prdata_next = rd_st;
            end else if (hit_ctrl) begin
                prdata_next = {30'h00000000, ctrl_reg};
            end else if (hit_idle) begin
                prdata_next = {16'h0000, idle_cnt_reg};
            end
        end
    end

    // ==========================================================
    // Flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WD_RUN; // [RULE_05]
            win_cnt_reg <= 17'h00000;
            wd_rel_reg <= 5'h00;
            cm_rel_reg <= 5'h00;
            gap_reg <= 20'h00000;
            cm_drive_reg <= 1'b0; // [RULE_05]
            sel_reg <= SEL_RESET; // [RULE_06]
            cm_en_reg <= CM_EN_RESET; // [RULE_06]
            first_done_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
            pend_reg <= 1'b0;
            halt_q_reg <= 1'b0;
            idle_q_reg <= 1'b0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            win_cnt_reg <= win_cnt_next;
            wd_rel_reg <= wd_rel_next;
            cm_rel_reg <= cm_rel_next;
            gap_reg <= gap_next;
            cm_drive_reg <= cm_drive_next;
            sel_reg <= sel_next;
            cm_en_reg <= cm_en_next;
            first_done_reg <= first_done_next;
            ctrl_reg <= ctrl_next;
            pend_reg <= pend_next;
            halt_q_reg <= halt_mode;
            idle_q_reg <= idle_mode;
            pready_reg <= psel & penable & ~pready_reg;
            pslverr_reg <= psel & penable & ~pready_reg & unmapped;
            prdata_reg <= prdata_next;
            oe_reg <= wd_drive | cm_drive_reg; // [RULE_23]
        end
    end

    // Free-running through reset; software may preload it
    always_ff @(posedge pclk) begin
        if (wr && hit_idle) begin
            idle_cnt_reg <= pwdata[15:0];
        end else if (instr_tick) begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001; // [RULE_21]
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign fault_out_n = 1'b0;
    assign fault_out_n_oe = oe_reg;

    // ==========================================================
    // Checks
    chk_reset_config: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
        !first_done_reg |-> sel_reg == 2'h3 && cm_en_reg)
        else $error("config not at reset value before first service");
    chk_early_error: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
        svc_wr && first_done_reg && early |=> state_reg == WD_DRIVE ##1 fault_out_n_oe)
        else $error("early service did not raise fault");
    chk_key_error: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
        svc_wr && !key_ok |=> state_reg == WD_DRIVE)
        else $error("bad key did not raise fault");
    chk_config_lock: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
        first_done_reg |=> $stable(sel_reg) && $stable(cm_en_reg))
        else $error("config changed after first service");
    chk_good_restart: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
        svc_good |=> win_cnt_reg == 17'h00000 && state_reg == WD_RUN)
        else $error("valid service did not restart window");
    chk_upper_timeout: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
        in_run && !inhibit && win_cnt_reg >= upper_bound(sel_reg) |=> state_reg == WD_DRIVE)
        else $error("window expiry missed");
    chk_ignore_driven: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
        wr && hit_svc && oe_reg && in_run && !idle_exit && !halt_reload
        |=> $stable(first_done_reg) && $stable(sel_reg) && $stable(cm_en_reg)
        && (!in_run || win_cnt_reg != 17'h00000 || $past(win_cnt_reg) == 17'h00000))
        else $error("service taken while fault driven");
    chk_halt_freeze: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_18]
        in_run && halt_mode && halt_q_reg ##1 halt_mode && in_run |-> $stable(win_cnt_reg))
        else $error("window counted during halt");
    chk_key_hidden: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
        rd && hit_svc |-> prdata[5:1] == 5'h00)
        else $error("key field visible on read");
    chk_cm_fault: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
        cm_en_reg && cm_slow |=> cm_drive_reg ##1 fault_out_n_oe)
        else $error("slow clock not flagged");
    cov_first_service: cover property (@(posedge pclk) disable iff (!presetn)
        svc_good && !first_done_reg);
    cov_wd_release: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == WD_RELEASED ##[1:20] in_run);
    cov_cm_recover: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(cm_drive_reg));
endmodule

// File: design/swcm_pkg.sv
/*
 Constants, register map and state codes for the service window timer
 with clock monitor. Assumes a 10 MHz APB clock and a one-cycle
 instruction tick supplied by the processor core.
*/
package swcm_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_SERVICE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_IDLE_CNT = 8'h0C;
    // ==========================================================
    // Service word fields
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 6;
    localparam int KEY_MSB = 5;
    localparam int KEY_LSB = 1;
    localparam int CM_BIT = 0;
    localparam logic [4:0] SVC_KEY = 5'h0C;
    localparam logic [1:0] SEL_RESET = 2'h3;
    localparam logic CM_EN_RESET = 1'b1;
    // ==========================================================
    // Status and control fields
    localparam int ST_PEND_BIT = 0;
    localparam int ST_WD_BIT = 1;
    localparam int ST_CM_BIT = 2;
    localparam int ST_FIRST_BIT = 3;
    localparam int CTRL_CLOCK_DELAY_SELECT_BIT = 0;
    localparam int CTRL_RC_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // ==========================================================
    // Timing, in instruction cycles unless named otherwise
    localparam logic [16:0] LOWER_TICKS = 17'h00800;
    localparam logic [16:0] UPPER_BASE_TICKS = 17'h02000;
    localparam logic [4:0] REL_TICKS = 5'h10;
    localparam logic [11:0] IDLE_WRAP = 12'hFFF;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CM_LIMIT_NS = 1000000;
    localparam int CM_LIMIT_CYCLES = CM_LIMIT_NS / CLK_PERIOD_NS;
    // ==========================================================
    // Supervisor states
    typedef enum logic [3:0] {
        WD_RUN = 4'b0001,
        WD_DRIVE = 4'b0010,
        WD_HOLD = 4'b0100,
        WD_RELEASED = 4'b1000
    } swcm_wd_state_type;
endpackage

// File: bench/swcm_pin_model.sv
/*
 Far side of the fault wire: pull-up plus the Schmitt input of the pin.
 Assumes the device only ever sinks the wire, never drives it high.
*/
`timescale 1ns/1ps
module swcm_pin_model (
    input wire logic pclk,
    input wire logic fault_out_n,
    input wire logic fault_out_n_oe,
    output logic shared_fault_pin
);
    // ==========================================================
    // Wire level
    logic wire_level;
    // Pull-up wins unless the device sinks the wire
    assign wire_level = (fault_out_n_oe && !fault_out_n) ? 1'b0 : 1'b1;
    initial shared_fault_pin = 1'b1;
    // One register stands for the Schmitt input, so the fall is seen late
    always @(posedge pclk) begin
        shared_fault_pin <= wire_level;
    end
endmodule

// File: bench/swcm_top_tb.sv
/*
 Self-checking bench for the service window timer and clock monitor.
 Assumes the pin model beside it and one instruction tick per two pclk.
*/
`timescale 1ns/1ps
module swcm_top_tb import swcm_pkg::*;;
    // ==========================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite, instr_tick, halt_mode;
    logic idle_mode, tick_en, pready, pslverr, pin, fo_n, oe, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int n_fail = 0;
    int samples_checked = 0;

    // Short monitor limit keeps the run brief; ticks come every 2 pclk
    swcm_top #(.CM_LIMIT(50)) i_swcm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick), .halt_mode(halt_mode),
        .idle_mode(idle_mode), .shared_fault_pin(pin), .fault_out_n(fo_n), .fault_out_n_oe(oe));
    swcm_pin_model i_swcm_pin_model (.pclk(pclk), .fault_out_n(fo_n), .fault_out_n_oe(oe),
        .shared_fault_pin(pin));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        instr_tick <= tick_en & ~instr_tick;
    end

    // ==========================================================
    // Helpers
    task check(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            check(1'b0, "no pready");
            summarize();
        end
    endtask
    task ticks(input int n);
        repeat (2 * n) @(posedge pclk);
    endtask
    // Waits for the drive, then times how long the wire is held
    // A non-zero d is written to the service word while the wire is held
    task fault(input int lim, input logic [31:0] d, input string m);
        int n;
        time t0;
        n = 0;
        while (oe !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        check(oe === 1'b1 && fo_n === 1'b0, m);
        tick_en <= 1'b1;
        t0 = $time;
        if (d != 32'h0) begin
            apb(1'b1, ADDR_SERVICE, d);
            check(oe === 1'b1, "write ended the fault");
        end
        n = int'(($time - t0) / CLK_PERIOD_NS);
        while (oe === 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        check(n >= 32 && n <= 72, "hold length");
        ticks(3);
    endtask
    task do_reset;
        presetn <= 1'b0;
        tick_en <= 1'b0;
        idle_mode <= 1'b0;
        repeat (10) @(posedge pclk);
        check(oe === 1'b0, "fault in reset");
        presetn <= 1'b1;
        tick_en <= 1'b1;
        @(posedge pclk);
    endtask

    // ==========================================================
    // Scenarios
    task t_regs;
        do_reset();
        apb(1'b0, ADDR_SERVICE, 32'h0);
        check(r === 32'hC1, "reset service word");
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(r === 32'h0 && e === 1'b0, "control reset");
        apb(1'b0, 8'h10, 32'h0);
        check(e === 1'b1 && r === 32'h0, "unmapped");
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(r === 32'h3, "control rw");
        tick_en <= 1'b0;
        ticks(20);
        check(oe === 1'b0, "monitor too early");
        fault(30, 32'h18, "monitor silent");
        apb(1'b0, ADDR_SERVICE, 32'h0);
        check(r === 32'hC1, "write in monitor fault taken");
    endtask
    task t_window;
        do_reset();
        ticks(100);
        apb(1'b1, ADDR_SERVICE, 32'h18);
        ticks(20);
        check(oe === 1'b0, "first service flagged");
        apb(1'b0, ADDR_SERVICE, 32'h0);
        check(r === 32'h0, "config not latched");
        tick_en <= 1'b0;
        ticks(60);
        check(oe === 1'b0, "monitor not disabled");
        tick_en <= 1'b1;
        ticks(2100);
        apb(1'b1, ADDR_CTRL, 32'h2);
        halt_mode <= 1'b1;
        ticks(5);
        halt_mode <= 1'b0;
        apb(1'b1, ADDR_SERVICE, 32'h18);
        ticks(10);
        check(oe === 1'b0, "valid service flagged");
        apb(1'b1, ADDR_SERVICE, 32'h18);
        fault(20, 32'hD9, "early service missed");
        ticks(20);
        check(oe === 1'b0, "write in fault seen");
        ticks(2100);
        apb(1'b1, ADDR_SERVICE, 32'h58);
        fault(20, 32'h0, "window mismatch missed");
        ticks(2100);
        apb(1'b1, ADDR_SERVICE, 32'h10);
        fault(20, 32'h0, "key mismatch missed");
        ticks(2100);
        apb(1'b1, ADDR_SERVICE, 32'h19);
        fault(20, 32'h0, "monitor bit mismatch missed");
    endtask
    task t_timeout(input logic [7:0] w, input int lo);
        do_reset();
        apb(1'b1, ADDR_SERVICE, {24'h0, w});
        repeat (lo - 300) @(posedge pclk);
        check(oe === 1'b0, "window too short");
        fault(700, 32'h0, "window too long");
    endtask
    task t_idle;
        do_reset();
        apb(1'b1, ADDR_IDLE_CNT, 32'hFFE);
        ticks(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(r[ST_PEND_BIT] === 1'b1, "pending not set");
        apb(1'b1, ADDR_STATUS, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(r[ST_PEND_BIT] === 1'b0, "pending not cleared");
        apb(1'b1, ADDR_SERVICE, 32'h18);
        ticks(2100);
        idle_mode <= 1'b1;
        ticks(6200);
        check(oe === 1'b0, "timer ran in idle");
        idle_mode <= 1'b0;
        ticks(4);
        apb(1'b1, ADDR_SERVICE, 32'h18);
        fault(20, 32'h0, "idle exit not a service");
        ticks(2100);
        halt_mode <= 1'b1;
        ticks(5);
        halt_mode <= 1'b0;
        ticks(4);
        apb(1'b1, ADDR_SERVICE, 32'h18);
        fault(20, 32'h0, "halt exit did not reload");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        instr_tick = 1'b0;
        tick_en = 1'b0;
        halt_mode = 1'b0;
        idle_mode = 1'b0;
        @(posedge pclk);
        t_regs();
        t_window();
        t_timeout(8'h19, 16384);
        t_timeout(8'h59, 32768);
        t_idle();
        summarize();
    end
endmodule
